// ---- tdsa_host_xfer.sv ----
// Purpose: Standalone-mode transfer sequencer of a turbo decoder coprocessor
// Assumes: DMA writes and reads aligned double words; datapath streams decisions
// Notes: Decision store holds 64 double words, i.e. frames up to 4096 bits
//
// Summary of operation
// - Permutation table arrives via one tx-request transfer, 8*ceil((FL+3)/4) bytes.
// - After decisions, and results when reported, are read, raise tx request for next config.
// - Decisions are read from the decision window via one rx-request transfer.
// - Decision readout is 8*ceil(FL/64) bytes; destination reserves as much.
// - Result block is a 16-byte rx-request readout at its offset.
// - Result-report flag set gives an rx request for the result block.
// - Reliability field holds length minus one; device adds one back.
// - Iteration ceiling of zero means thirty-two.
// - Zero quality threshold disables threshold stopping.
// - Correction enable picks max-log-MAP (0) or full log-MAP (1).
// - Threshold stopping runs at least the floor, held within 1 to 31.
// - Polarity invert negates every incoming soft value.
// - Bit reverse packs decisions from bit 31 down, then from bit 63 down, instead of bit 0 up.
// - Warm-up shortening enable turns prolog reduction on.
// - Any zero checksum setting disables checksum early stop.
// - Permutation table follows symbols only when the reload flag is set.
// - Each channel starts with 64 bytes of configuration at the config window.
// - Symbols follow the configuration into the symbol window.
`timescale 1ns/1ps
module tdsa_host_xfer import tdsa_pkg::*; (
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic [31:0] I_ADDR,
	input wire logic [63:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [63:0] O_RDATA,
	output logic O_TX_REQUEST_EVENT,
	output logic O_RX_REQUEST_EVENT,
	output logic O_DECODE_START,
	output logic O_MODE_REJECT,
	output logic O_SYM_WE,
	output logic [15:0] O_SYM_ADDR,
	output logic [63:0] O_SYM_DATA,
	output logic O_PERM_WE,
	output logic [15:0] O_PERM_ADDR,
	output logic [63:0] O_PERM_DATA,
	input wire logic I_DEC_VALID,
	input wire logic I_DEC_BIT,
	input wire logic I_DEC_DONE,
	input wire logic [95:0] I_RESULT,
	output logic [FL_W-1:0] O_FRAME_LEN,
	output logic [6:0] O_REL_LEN,
	output logic [5:0] O_ITER_MAX,
	output logic [4:0] O_ITER_MIN,
	output logic O_SNR_EN,
	output logic [4:0] O_SNR_THR,
	output logic O_LOG_MAP,
	output logic O_WARMUP_EN,
	output logic O_CRC_EN
);
	tdsa_state_t st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [31:0] cfg_q [CW_USED], cfg_d [CW_USED];
	logic boot_q, boot_d;
	logic tx_q, tx_d, rx_q, rx_d, start_q, start_d, rej_q, rej_d;
	logic sym_we_q, sym_we_d, perm_we_q, perm_we_d;
	logic [15:0] sym_addr_q, sym_addr_d, perm_addr_q, perm_addr_d;
	logic [63:0] sym_data_q, sym_data_d, perm_data_q, perm_data_d;
	logic [63:0] dmem_q [DEC_DEPTH], dmem_d [DEC_DEPTH];
	logic [11:0] dpos_q, dpos_d;
	logic [63:0] rdata_q, rdata_d;
	logic [95:0] res_q, res_d;
	logic [FL_W-1:0] fl;
	logic [15:0] sym_dw, perm_dw, hd_dw, off;
	logic aligned, wr_ok, in_cfg, in_sym, in_perm, in_dec;
	logic reload_flag, report_flag, polarity, bitrev;

	// Floor of (v + add) / 2^sh, sized for the counters
	function automatic logic [15:0] ceil_dw(input logic [FL_W-1:0] v, input logic [6:0] add,
		input int sh);
		logic [16:0] s;
		s = {2'b00, v} + {10'h000, add};
		return 16'(s >> sh);
	endfunction

	// Negate eight signed soft values; -128 saturates since +128 does not fit
	function automatic logic [63:0] neg_soft(input logic [63:0] w);
		logic [63:0] r;
		r = 64'h0000_0000_0000_0000;
		for (int i = 0; i < 8; i++) begin
			r[i*8 +: 8] = (w[i*8 +: 8] == 8'h80) ? 8'h7f : 8'(-w[i*8 +: 8]);
		end
		return r;
	endfunction

	// Window hit on the upper address half
	function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base);
		return a[31:16] == base[31:16];
	endfunction

	// Field views of the captured words
	always_comb begin
		fl = cfg_q[0][FL_LSB +: FL_W];
		reload_flag = cfg_q[0][RLD_BIT];
		report_flag = cfg_q[0][RPT_BIT];
		polarity = cfg_q[3][POL_BIT];
		bitrev = cfg_q[3][BREV_BIT];
		sym_dw = ceil_dw(fl, 7'd1, 1);
		perm_dw = ceil_dw(fl, 7'd6, 2);
		hd_dw = ceil_dw(fl, 7'd63, 6);
		off = I_ADDR[15:0];
		aligned = (I_ADDR[DW_SHIFT-1:0] == 3'h0);
		wr_ok = I_WR && aligned;
		in_cfg = win_hit(I_ADDR, CFG_BASE) && (off < CFG_LIMIT);
		in_sym = win_hit(I_ADDR, SYM_BASE);
		in_perm = win_hit(I_ADDR, PERM_BASE);
		in_dec = win_hit(I_ADDR, DEC_BASE);
	end

	// Transfer sequencer and inbound data
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		cfg_d = cfg_q;
		boot_d = 1'b0;
		tx_d = 1'b0;
		rx_d = 1'b0;
		start_d = 1'b0;
		rej_d = rej_q;
		sym_we_d = 1'b0;
		sym_addr_d = sym_addr_q;
		sym_data_d = sym_data_q;
		perm_we_d = 1'b0;
		perm_addr_d = perm_addr_q;
		perm_data_d = perm_data_q;
		// First config request once after reset
		if (boot_q) begin
			tx_d = 1'b1;
		end
		unique case (st_q)
			ST_CFG: begin
				if (wr_ok && in_cfg) begin
					// Low word of a double word is the even configuration word
					for (int i = 0; i < CW_USED; i++) begin
						if (16'(i >> 1) == (off >> DW_SHIFT)) begin
							cfg_d[i] = (i % 2 == 0) ? I_WDATA[31:0] : I_WDATA[63:32];
						end
					end
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q + 16'h0001 >= CFG_DW) begin
						cnt_d = 16'h0000;
						st_d = ST_SYM;
						tx_d = 1'b1;
					end
				end
			end
			ST_SYM: begin
				if (wr_ok && in_sym) begin
					sym_we_d = 1'b1;
					sym_addr_d = off >> DW_SHIFT;
					sym_data_d = polarity ? neg_soft(I_WDATA) : I_WDATA;
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q + 16'h0001 >= sym_dw) begin
						cnt_d = 16'h0000;
						if (cfg_q[0][OPM_LSB +: 2] != OPM_STANDALONE) begin
							// Not a standalone channel: drop it and ask for the next
							rej_d = 1'b1;
							st_d = ST_CFG;
							tx_d = 1'b1;
						end else if (reload_flag) begin
							st_d = ST_PERM;
							tx_d = 1'b1;
						end else begin
							st_d = ST_DEC;
							start_d = 1'b1;
						end
					end
				end
			end
			ST_PERM: begin
				if (wr_ok && in_perm) begin
					perm_we_d = 1'b1;
					perm_addr_d = off >> DW_SHIFT;
					perm_data_d = I_WDATA;
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q + 16'h0001 >= perm_dw) begin
						cnt_d = 16'h0000;
						st_d = ST_DEC;
						start_d = 1'b1;
					end
				end
			end
			ST_DEC: begin
				if (I_DEC_DONE) begin
					st_d = ST_HD;
					rx_d = 1'b1;
				end
			end
			ST_HD: begin
				if (I_RD && aligned && in_dec) begin
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q + 16'h0001 >= hd_dw) begin
						cnt_d = 16'h0000;
						if (report_flag) begin
							st_d = ST_RES;
							rx_d = 1'b1;
						end else begin
							st_d = ST_CFG;
							tx_d = 1'b1;
						end
					end
				end
			end
			ST_RES: begin
				if (I_RD && aligned && ((I_ADDR == RES_ADDR0) || (I_ADDR == RES_ADDR1))) begin
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q + 16'h0001 >= RES_DW) begin
						cnt_d = 16'h0000;
						st_d = ST_CFG;
						tx_d = 1'b1;
					end
				end
			end
		endcase
		if (st_q == ST_CFG && st_d == ST_SYM) begin
			rej_d = 1'b0;
		end
	end

	// Sequencer registers
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st_q <= ST_CFG;
			cnt_q <= 16'h0000;
			for (int i = 0; i < CW_USED; i++) begin
				cfg_q[i] <= 32'h0000_0000;
			end
			boot_q <= 1'b1;
			tx_q <= 1'b0;
			rx_q <= 1'b0;
			start_q <= 1'b0;
			rej_q <= 1'b0;
			sym_we_q <= 1'b0;
			sym_addr_q <= 16'h0000;
			sym_data_q <= 64'h0000_0000_0000_0000;
			perm_we_q <= 1'b0;
			perm_addr_q <= 16'h0000;
			perm_data_q <= 64'h0000_0000_0000_0000;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			cfg_q <= cfg_d;
			boot_q <= boot_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			start_q <= start_d;
			rej_q <= rej_d;
			sym_we_q <= sym_we_d;
			sym_addr_q <= sym_addr_d;
			sym_data_q <= sym_data_d;
			perm_we_q <= perm_we_d;
			perm_addr_q <= perm_addr_d;
			perm_data_q <= perm_data_d;
		end
	end

	// Decision packing, result capture and read data
	always_comb begin
		logic [5:0] bitpos;
		logic [DEC_AW-1:0] ridx;
		bitpos = dpos_q[5:0];
		ridx = off[DEC_AW+DW_SHIFT-1:DW_SHIFT];
		dmem_d = dmem_q;
		dpos_d = dpos_q;
		res_d = res_q;
		rdata_d = 64'h0000_0000_0000_0000;
		// Clear the store at decode start so short frames read zero padding
		if (start_q) begin
			for (int i = 0; i < DEC_DEPTH; i++) begin
				dmem_d[i] = 64'h0000_0000_0000_0000;
			end
			dpos_d = 12'h000;
		end else if (st_q == ST_DEC && I_DEC_VALID) begin
			// Bit 5 picks the 32-bit half; bit order within a half is selectable
			if (bitrev) begin
				bitpos = {dpos_q[5], ~dpos_q[4:0]};
			end
			dmem_d[dpos_q[11:6]][bitpos] = I_DEC_BIT;
			dpos_d = dpos_q + 12'h001;
		end
		if (st_q == ST_DEC && I_DEC_DONE) begin
			res_d = I_RESULT;
		end
		// Read answers; anything unmapped or misaligned reads zero
		if (I_RD && aligned) begin
			if (in_dec && off < 16'(DEC_DEPTH << DW_SHIFT)) begin
				rdata_d = dmem_q[ridx];
			end else if (I_ADDR == RES_ADDR0) begin
				rdata_d = res_q[63:0];
			end else if (I_ADDR == RES_ADDR1) begin
				rdata_d = {32'h0000_0000, res_q[95:64]};
			end else if (I_ADDR == STAT_ADDR) begin
				rdata_d = {48'h0000_0000_0000, 2'b00, FL_W'(0) == fl, rej_q, report_flag,
					reload_flag, 7'h00, st_q};
			end
		end
	end

	// Decision store and read registers
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < DEC_DEPTH; i++) begin
				dmem_q[i] <= 64'h0000_0000_0000_0000;
			end
			dpos_q <= 12'h000;
			res_q <= 96'h0000_0000_0000_0000_0000_0000;
			rdata_q <= 64'h0000_0000_0000_0000;
		end else begin
			dmem_q <= dmem_d;
			dpos_q <= dpos_d;
			res_q <= res_d;
			rdata_q <= rdata_d;
		end
	end

	// Setting interpretation
	tdsa_cfg_decode u_cfg (
		.i_clk(I_REF_CLK),
		.i_arst_n(I_ARST_N),
		.i_word1(cfg_q[1]),
		.i_word2(cfg_q[2]),
		.i_word3(cfg_q[3]),
		.i_word4(cfg_q[4]),
		.i_word5(cfg_q[5]),
		.o_rel_len(O_REL_LEN),
		.o_iter_max(O_ITER_MAX),
		.o_iter_min(O_ITER_MIN),
		.o_snr_en(O_SNR_EN),
		.o_snr_thr(O_SNR_THR),
		.o_log_map(O_LOG_MAP),
		.o_warmup_en(O_WARMUP_EN),
		.o_crc_en(O_CRC_EN)
	);

	// Registered outputs
	assign O_RDATA = rdata_q;
	assign O_TX_REQUEST_EVENT = tx_q;
	assign O_RX_REQUEST_EVENT = rx_q;
	assign O_DECODE_START = start_q;
	assign O_MODE_REJECT = rej_q;
	assign O_SYM_WE = sym_we_q;
	assign O_SYM_ADDR = sym_addr_q;
	assign O_SYM_DATA = sym_data_q;
	assign O_PERM_WE = perm_we_q;
	assign O_PERM_ADDR = perm_addr_q;
	assign O_PERM_DATA = perm_data_q;
	assign O_FRAME_LEN = cfg_q[0][FL_LSB +: FL_W];
endmodule

// ---- tdsa_pkg.sv ----
// Purpose: Shared constants and types for the standalone host transfer sequencer
// Assumes: 64-bit data windows, byte addresses on a 32-bit address port
// Notes: Field positions inside configuration words are local choices
package tdsa_pkg;
	// Data windows seen by the system DMA
	localparam logic [31:0] CFG_BASE = 32'h5000_0000;
	localparam logic [31:0] RES_ADDR0 = 32'h5000_0030;
	localparam logic [31:0] RES_ADDR1 = 32'h5000_0038;
	localparam logic [31:0] STAT_ADDR = 32'h5000_0080;
	localparam logic [31:0] SYM_BASE = 32'h5001_0000;
	localparam logic [31:0] PERM_BASE = 32'h5005_0000;
	localparam logic [31:0] DEC_BASE = 32'h5006_0000;
	localparam logic [15:0] CFG_LIMIT = 16'h0040;
	// Transfer sizes in double words
	localparam logic [15:0] CFG_DW = 16'h0008;
	localparam logic [15:0] RES_DW = 16'h0002;
	localparam int DW_SHIFT = 3;
	// Decision store
	localparam int DEC_AW = 6;
	localparam int DEC_DEPTH = 64;
	localparam int FL_W = 15;
	// Configuration word layout
	localparam int CW_USED = 6;
	localparam int FL_LSB = 0;
	localparam int OPM_LSB = 16;
	localparam int RLD_BIT = 20;
	localparam int RPT_BIT = 21;
	localparam int REL_LSB = 0;
	localparam int MAXI_LSB = 0;
	localparam int SNR_LSB = 8;
	localparam int LMAP_BIT = 0;
	localparam int POL_BIT = 1;
	localparam int BREV_BIT = 2;
	localparam int WUP_BIT = 3;
	localparam int MINI_LSB = 8;
	localparam int CRCL_LSB = 0;
	localparam int CRCI_LSB = 8;
	localparam int POLY_LSB = 0;
	localparam logic [1:0] OPM_STANDALONE = 2'h0;
	localparam logic [5:0] ITER_CEILING_MAX = 6'h20;
	localparam logic [4:0] ITER_FLOOR_LO = 5'h01;
	localparam logic [4:0] ITER_FLOOR_HI = 5'h1f;
	// Sequencer states, Gray coded along the transfer order
	typedef enum logic [2:0] {
		ST_CFG = 3'b000,
		ST_SYM = 3'b001,
		ST_PERM = 3'b011,
		ST_DEC = 3'b010,
		ST_HD = 3'b110,
		ST_RES = 3'b111
	} tdsa_state_t;
endpackage

// ---- tdsa_cfg_decode.sv ----
// Purpose: Interprets captured configuration words into registered settings
// Assumes: Words are stable while a channel is processed
// Notes: Outputs lag the words by one clock
`timescale 1ns/1ps
module tdsa_cfg_decode import tdsa_pkg::*; (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [31:0] i_word1,
	input wire logic [31:0] i_word2,
	input wire logic [31:0] i_word3,
	input wire logic [31:0] i_word4,
	input wire logic [31:0] i_word5,
	output logic [6:0] o_rel_len,
	output logic [5:0] o_iter_max,
	output logic [4:0] o_iter_min,
	output logic o_snr_en,
	output logic [4:0] o_snr_thr,
	output logic o_log_map,
	output logic o_warmup_en,
	output logic o_crc_en
);
	logic [6:0] rel_d;
	logic [5:0] imax_d;
	logic [4:0] imin_d;
	logic [4:0] quality_threshold_ratio;
	logic [4:0] mini;
	logic [4:0] maxi;
	logic snr_en_d;
	logic crc_en_d;

	// Field interpretation
	always_comb begin
		quality_threshold_ratio = i_word2[SNR_LSB +: 5];
		maxi = i_word2[MAXI_LSB +: 5];
		mini = i_word3[MINI_LSB +: 5];
		rel_d = {1'b0, i_word1[REL_LSB +: 6]} + 7'h01;
		imax_d = (maxi == 5'h00) ? ITER_CEILING_MAX : {1'b0, maxi};
		snr_en_d = (quality_threshold_ratio != 5'h00);
		// Floor only matters with threshold stopping; keep it in the legal range
		imin_d = !snr_en_d ? ITER_FLOOR_LO :
			(mini < ITER_FLOOR_LO) ? ITER_FLOOR_LO : mini;
		if (imin_d > ITER_FLOOR_HI) begin
			imin_d = ITER_FLOOR_HI;
		end
		// Any zeroed checksum setting turns the checksum stop off
		crc_en_d = (i_word4[CRCL_LSB +: 5] != 5'h00) && (i_word4[CRCI_LSB +: 5] != 5'h00) &&
			(i_word5[POLY_LSB +: 24] != 24'h00_0000);
	end

	// Registered settings
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rel_len <= 7'h01;
			o_iter_max <= ITER_CEILING_MAX;
			o_iter_min <= ITER_FLOOR_LO;
			o_snr_en <= 1'b0;
			o_snr_thr <= 5'h00;
			o_log_map <= 1'b0;
			o_warmup_en <= 1'b0;
			o_crc_en <= 1'b0;
		end else begin
			o_rel_len <= rel_d;
			o_iter_max <= imax_d;
			o_iter_min <= imin_d;
			o_snr_en <= snr_en_d;
			o_snr_thr <= quality_threshold_ratio;
			o_log_map <= i_word3[LMAP_BIT];
			o_warmup_en <= i_word3[WUP_BIT];
			o_crc_en <= crc_en_d;
		end
	end
endmodule

// ---- tdsa_host_xfer_monitor.sv ----
// Purpose: Port checks for the standalone transfer sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound onto every sequencer instance
`timescale 1ns/1ps
module tdsa_host_xfer_chk import tdsa_pkg::*; (
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic [31:0] I_ADDR,
	input wire logic [63:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_DEC_DONE,
	input wire logic [63:0] O_RDATA,
	input wire logic O_TX_REQUEST_EVENT,
	input wire logic O_RX_REQUEST_EVENT,
	input wire logic O_DECODE_START,
	input wire logic O_SYM_WE,
	input wire logic [15:0] O_SYM_ADDR,
	input wire logic O_PERM_WE,
	input wire logic [63:0] O_PERM_DATA,
	input wire logic [5:0] O_ITER_MAX,
	input wire logic [4:0] O_ITER_MIN,
	input wire logic O_SNR_EN
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_ARST_N);
	// Bus answers and datapath writes
	chk_rdata_quiet: assert property (!$past(I_RD) |-> O_RDATA == 64'h0)
		else $error("read data outside its slot");
	chk_sym_cause: assert property (O_SYM_WE |-> $past(I_WR) &&
		$past(I_ADDR[31:16]) == SYM_BASE[31:16]) else $error("symbol write without cause");
	chk_sym_index: assert property (O_SYM_WE |-> O_SYM_ADDR == {3'b000, $past(I_ADDR[15:3])})
		else $error("symbol index wrong");
	chk_perm_copy: assert property (O_PERM_WE |-> O_PERM_DATA == $past(I_WDATA) &&
		$past(I_ADDR[31:16]) == PERM_BASE[31:16]) else $error("table write wrong");
	// Decoded settings stay in their legal ranges
	chk_ceiling_range: assert property (O_ITER_MAX inside {[1:32]})
		else $error("iteration ceiling out of range");
	chk_floor_range: assert property (O_SNR_EN |-> O_ITER_MIN inside {[1:31]})
		else $error("iteration floor out of range");
	// Request and decode-start events and their causes
	chk_req_exclusive: assert property (!(O_TX_REQUEST_EVENT && O_RX_REQUEST_EVENT))
		else $error("both requests at once");
	chk_tx_single: assert property (O_TX_REQUEST_EVENT |=> !O_TX_REQUEST_EVENT)
		else $error("transmit request not a pulse");
	chk_rx_after_done: assert property (I_DEC_DONE |=> O_RX_REQUEST_EVENT)
		else $error("no decision request after decode");
	chk_rx_cause: assert property (O_RX_REQUEST_EVENT |-> $past(I_DEC_DONE) || $past(I_RD))
		else $error("receive request without cause");
	chk_start_cause: assert property (O_DECODE_START |-> $past(I_WR))
		else $error("decode start without inbound write");
endmodule

bind tdsa_host_xfer tdsa_host_xfer_chk u_chk (.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N),
	.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_DEC_DONE(I_DEC_DONE),
	.O_RDATA(O_RDATA), .O_TX_REQUEST_EVENT(O_TX_REQUEST_EVENT),
	.O_RX_REQUEST_EVENT(O_RX_REQUEST_EVENT), .O_DECODE_START(O_DECODE_START),
	.O_SYM_WE(O_SYM_WE), .O_SYM_ADDR(O_SYM_ADDR), .O_PERM_WE(O_PERM_WE),
	.O_PERM_DATA(O_PERM_DATA), .O_ITER_MAX(O_ITER_MAX), .O_ITER_MIN(O_ITER_MIN),
	.O_SNR_EN(O_SNR_EN));

// ---- tdsa_dec_model.sv ----
// Purpose: Behavioural decoder datapath that streams decisions back
// Assumes: Frame length is stable from decode start to done
// Notes: Decision n is n[0] xor n[2]; result value is a parameter
`timescale 1ns/1ps
module tdsa_dec_model import tdsa_pkg::*; #(
	parameter logic [95:0] RESULT = 96'h0
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_start,
	input wire logic [FL_W-1:0] i_fl,
	output logic o_valid,
	output logic o_bit,
	output logic o_done,
	output logic [95:0] o_result
);
	logic busy_q;
	logic [FL_W-1:0] cnt_q;
	// One bit a cycle, then a done pulse
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
			o_done <= 1'b0;
		end else begin
			o_done <= busy_q && (cnt_q == i_fl - 15'h1);
			if (i_start) begin
				busy_q <= 1'b1;
				cnt_q <= '0;
			end else if (busy_q) begin
				cnt_q <= cnt_q + 15'h1;
				busy_q <= (cnt_q != i_fl - 15'h1);
			end
		end
	end
	// Bit line inverted while idle so stale values never look valid
	assign o_valid = busy_q;
	assign o_bit = (cnt_q[0] ^ cnt_q[2]) ^ !busy_q;
	assign o_result = RESULT;
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the standalone transfer sequencer
// Assumes: Bench acts as the DMA master; model acts as datapath
// Notes: Three channels: full, dropped mode, no table and no result
`timescale 1ns/1ps
module tb_top import tdsa_pkg::*;;
	localparam logic [95:0] RES_VAL = 96'h1234_5678_9abc_def0_0f1e_2d3c;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [63:0] wdata = 64'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [63:0] rdata, sym_data, perm_data;
	logic tx_ev, rx_ev, start_ev, mode_rej, sym_we, perm_we, dvalid, dbit, ddone;
	logic snr_en, log_map, warmup_en, crc_en;
	logic [15:0] sym_addr, perm_addr;
	logic [95:0] result;
	logic [FL_W-1:0] frame_len;
	logic [6:0] rel_len;
	logic [5:0] iter_max;
	logic [4:0] iter_min, snr_thr;
	logic [31:0] cw [0:15];
	logic pol, brev, rld, rpt;
	int fl, opm;
	int miscompares = 0;
	int checks_done = 0;
	// 40 MHz reference
	always #12.5 ref_clk = ~ref_clk;
	tdsa_host_xfer DUT (.I_REF_CLK(ref_clk), .I_ARST_N(arst_n), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_TX_REQUEST_EVENT(tx_ev),
		.O_RX_REQUEST_EVENT(rx_ev), .O_DECODE_START(start_ev), .O_MODE_REJECT(mode_rej),
		.O_SYM_WE(sym_we), .O_SYM_ADDR(sym_addr), .O_SYM_DATA(sym_data), .O_PERM_WE(perm_we),
		.O_PERM_ADDR(perm_addr), .O_PERM_DATA(perm_data), .I_DEC_VALID(dvalid),
		.I_DEC_BIT(dbit), .I_DEC_DONE(ddone), .I_RESULT(result), .O_FRAME_LEN(frame_len),
		.O_REL_LEN(rel_len), .O_ITER_MAX(iter_max), .O_ITER_MIN(iter_min),
		.O_SNR_EN(snr_en), .O_SNR_THR(snr_thr), .O_LOG_MAP(log_map),
		.O_WARMUP_EN(warmup_en), .O_CRC_EN(crc_en));
	tdsa_dec_model #(.RESULT(RES_VAL)) u_dec (.i_clk(ref_clk), .i_arst_n(arst_n),
		.i_start(start_ev), .i_fl(frame_len), .o_valid(dvalid), .o_bit(dbit),
		.o_done(ddone), .o_result(result));
	// Compare helper
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Write holds its strobe; bus_end drops it without using an edge
	task automatic bus_wr(input logic [31:0] a, input logic [63:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
	endtask
	task automatic bus_end();
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic bus_rd(input logic [31:0] a, output logic [63:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(posedge ref_clk);
		d = rdata;
	endtask
	// Waits for the next event; looks at the current cycle first
	task automatic wev(output logic [2:0] ev);
		ev = {start_ev, rx_ev, tx_ev};
		for (int i = 0; i < 400 && ev == 3'b000; i++) begin
			@(posedge ref_clk);
			ev = {start_ev, rx_ev, tx_ev};
		end
	endtask
	function automatic logic [63:0] neg64(input logic [63:0] v);
		logic [7:0] b;
		for (int i = 0; i < 8; i++) begin
			b = v[8*i +: 8];
			neg64[8*i +: 8] = (b == 8'h80) ? 8'h7f : 8'h00 - b;
		end
	endfunction
	// One channel; caller has already seen the configuration request
	task automatic run_ch();
		logic [2:0] ev;
		logic [63:0] d, e;
		logic [5:0] bp;
		for (int k = 0; k < 8; k++) bus_wr(CFG_BASE + 8 * k, {cw[2*k+1], cw[2*k]});
		bus_end();
		wev(ev);
		chk("symbol request", ev, 3'b001);
		for (int k = 0; k < (fl + 1) / 2; k++) begin
			d = 64'h8001_7fff_0010_2030 + k;
			bus_wr(SYM_BASE + 8 * k, d);
			bus_end();
			@(posedge ref_clk);
			chk("sym we", sym_we, 1'b1);
			chk("sym addr", sym_addr, k);
			chk("sym data", sym_data, pol ? neg64(d) : d);
		end
		if (opm != 0) begin
			wev(ev);
			chk("drop request", ev, 3'b001);
			@(posedge ref_clk);
			chk("reject", mode_rej, 1'b1);
			return;
		end
		if (rld) begin
			wev(ev);
			chk("table request", ev, 3'b001);
			for (int k = 0; k < (fl + 6) / 4; k++) begin
				bus_wr(PERM_BASE + 8 * k, 64'hc3a5_0000_0000_0000 + k);
				bus_end();
				@(posedge ref_clk);
				chk("perm addr", perm_addr, k);
				chk("perm we", perm_we, 1'b1);
			end
		end
		wev(ev);
		chk("decode start", ev, 3'b100);
		// Step past the start pulse so the next wait cannot see it again
		@(posedge ref_clk);
		wev(ev);
		chk("decision request", ev, 3'b010);
		for (int w = 0; w < (fl + 63) / 64; w++) begin
			e = '0;
			for (int n = 64 * w; n < fl && n < 64 * w + 64; n++) begin
				bp = brev ? {n[5], ~n[4:0]} : n[5:0];
				e[bp] = n[0] ^ n[2];
			end
			bus_rd(DEC_BASE + 8 * w, d);
			chk("decisions", d, e);
		end
		// Result readout only when asked for
		if (rpt) begin
			wev(ev);
			chk("result request", ev, 3'b010);
			bus_rd(RES_ADDR0, d);
			chk("result low", d, RES_VAL[63:0]);
			bus_rd(RES_ADDR1, d);
			chk("result high", d, {32'h0000_0000, RES_VAL[95:64]});
		end
		wev(ev);
		chk("next config request", ev, 3'b001);
	endtask
	// Refused accesses and a status read before the first channel
	task automatic test_bus();
		logic [63:0] d;
		bus_wr(SYM_BASE, 64'h1);
		bus_wr(CFG_BASE + 4, 64'h2);
		bus_end();
		@(posedge ref_clk);
		chk("early sym we", sym_we, 1'b0);
		bus_rd(CFG_BASE + 4, d);
		chk("misaligned read", d, 64'h0);
		bus_rd(32'h5000_0100, d);
		chk("unmapped read", d, 64'h0);
		bus_rd(STAT_ADDR, d);
		chk("status", d, 64'h2000);
		$display("test_bus done");
	endtask
	// Table, result, inverted input, zero ceiling and threshold
	task automatic test_ch_a();
		{fl, opm, pol, brev, rld, rpt} = {32'd10, 32'd0, 4'b1011};
		cw[0] = 32'h0030_000a;
		cw[1] = 32'h0000_0005;
		cw[2] = 32'h0000_0000;
		cw[3] = 32'h0000_0b0b;
		cw[4] = 32'h0000_0308;
		cw[5] = 32'h0000_1021;
		run_ch();
		chk("frame len", frame_len, 15'd10);
		chk("rel len", rel_len, 7'd6);
		chk("iter max", iter_max, 6'd32);
		chk("snr en", snr_en, 1'b0);
		chk("iter min", iter_min, 5'd1);
		chk("log map", log_map, 1'b1);
		chk("warmup", warmup_en, 1'b1);
		chk("crc en", crc_en, 1'b1);
		$display("test_ch_a done");
	endtask
	// Non-standalone mode is dropped after its symbols
	task automatic test_reject();
		{fl, opm, pol, brev, rld, rpt} = {32'd70, 32'd1, 4'b0100};
		cw[0] = 32'h0001_0046;
		cw[2] = 32'h0000_0407;
		cw[3] = 32'h0000_1f04;
		cw[4] = 32'h0000_0300;
		run_ch();
		$display("test_reject done");
	endtask
	// Two decision words, reversed packing, no table, no result
	task automatic test_ch_b();
		{fl, opm, pol, brev, rld, rpt} = {32'd70, 32'd0, 4'b0100};
		cw[0] = 32'h0000_0046;
		cw[1] = 32'h0000_0000;
		run_ch();
		chk("rel len", rel_len, 7'd1);
		chk("iter max", iter_max, 6'd7);
		chk("snr thr", {snr_en, snr_thr}, 6'h24);
		chk("iter min", iter_min, 5'd31);
		chk("log map", log_map, 1'b0);
		chk("warmup", warmup_en, 1'b0);
		chk("crc en", crc_en, 1'b0);
		chk("reject", mode_rej, 1'b0);
		$display("test_ch_b done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence; the last request is left unanswered, never met by a stray access
	initial begin
		logic [2:0] ev;
		for (int i = 0; i < 16; i++) cw[i] = 32'h0;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		wev(ev);
		chk("first request", ev, 3'b001);
		test_bus();
		test_ch_a();
		test_reject();
		test_ch_b();
		test_done();
	end
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#200000;
		miscompares++;
		$display("watchdog expired");
		test_done();
	end
endmodule
